// >>> dv/board_reset_model.sv
`timescale 1ns/1ps
module board_reset_model (
	// Device side
	input  wire logic       clk_sys,
	input  wire logic       pin_out,
	input  wire logic       pin_oe,
	// Board controls
	input  wire logic       button,
	input  wire logic [5:0] rise_cycles,
	// Wire level
	output logic            pin_level
);
	logic [5:0] rise_cnt;
	logic       held_low;

	assign held_low = (pin_oe && !pin_out) || button;
	initial rise_cnt = 6'h00;
	// Pull-up charges the board capacitance; a slow rise models a too-large cap
	always @(posedge clk_sys) begin
		if (held_low) begin
			rise_cnt <= 6'h00;
		end else if (rise_cnt < rise_cycles) begin
			rise_cnt <= rise_cnt + 6'h01;
		end
	end
	assign pin_level = !held_low && (rise_cnt >= rise_cycles);
endmodule // board_reset_model

// >>> dv/pad_reset_defaults_asserts.sv
`timescale 1ns/1ps
module pad_reset_defaults_asserts
	import pad_reset_pkg::*;
#(
	parameter int DRIVE_CYCLES   = RST_DRIVE_CYCLES,
	parameter int RELEASE_CYCLES = RST_RELEASE_CYCLES
)(
	// Clock, reset and pin
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       reset_pin_in,
	input wire logic       reset_pin_out_ff,
	input wire logic       reset_pin_oe_ff,
	input wire logic       watchdog_timer_fail,
	// Pull state and drive enables
	input wire logic [7:0] drive_en_e,
	input wire logic [7:0] drive_en_m,
	input wire logic       debug_line_pullup_ff,
	input wire pull_t      pull_a_ff,
	input wire pull_t      pull_b_ff,
	input wire pull_t      pull_e_ff,
	input wire pull_t      pull_m_ff,
	// Sequencer
	input wire logic       device_reset_n_ff,
	input wire logic       clk_from_osc_ff
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	open_drain_a: assert property (reset_pin_out_ff == 1'b0)
		else $error("reset pin driven high");
	debug_pull_a: assert property (debug_line_pullup_ff == 1'b1)
		else $error("debug line pull-up off");
	osc_clock_a: assert property (clk_from_osc_ff == 1'b1)
		else $error("clock not from oscillator");
	// Four cycles let the register and pull stages settle after entry
	ab_pull_off_a: assert property (!device_reset_n_ff [*4] |-> pull_a_ff == '0 && pull_b_ff == '0)
		else $error("port A/B pulls active in reset");
	e_reset_down_a: assert property (!device_reset_n_ff [*4] ##0 $past(drive_en_e) == 8'h00
		|-> pull_e_ff.down[6:5] == 2'b11)
		else $error("mode pins not pulled down in reset");
	e_run_nodown_a: assert property (device_reset_n_ff [*3] |-> pull_e_ff.down[6:5] == 2'b00)
		else $error("mode pin pull-down left on");
	m_reset_up_a: assert property (!device_reset_n_ff [*4] ##0 $past(drive_en_m) == 8'h00
		|-> pull_m_ff.up == 8'hFF)
		else $error("port M not pulled up in reset");
	drive_drops_a: assert property ($past(rst_n) |->
		((pull_m_ff.up | pull_m_ff.down) & $past(drive_en_m)) == 8'h00)
		else $error("pull on a driven pin");
	fail_pulls_a: assert property ($rose(watchdog_timer_fail) && device_reset_n_ff
		|-> ##[1:5] reset_pin_oe_ff)
		else $error("failure did not pull reset pin");
	pin_resets_a: assert property ($fell(reset_pin_in) && !reset_pin_oe_ff && device_reset_n_ff
		|-> ##[1:5] !device_reset_n_ff)
		else $error("low pin did not reset device");
	run_release_a: assert property ($rose(device_reset_n_ff)
		|-> !reset_pin_oe_ff && $past(reset_pin_in) && $past(reset_pin_oe_ff, 2) == 1'b0)
		else $error("run began without pin release");

	cover property ($rose(device_reset_n_ff));
	cover property ($rose(watchdog_timer_fail) ##[1:5] reset_pin_oe_ff);
	cover property ($fell(reset_pin_in) && !reset_pin_oe_ff);
endmodule // pad_reset_defaults_asserts

bind pad_reset_defaults pad_reset_defaults_asserts #(
	.DRIVE_CYCLES(DRIVE_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES)
) u_asserts (.clk_sys, .rst_n, .reset_pin_in, .reset_pin_out_ff, .reset_pin_oe_ff,
	.watchdog_timer_fail, .drive_en_e, .drive_en_m, .debug_line_pullup_ff, .pull_a_ff,
	.pull_b_ff, .pull_e_ff, .pull_m_ff, .device_reset_n_ff, .clk_from_osc_ff);

// >>> dv/pad_reset_defaults_tb_top.sv
`timescale 1ns/1ps
module pad_reset_defaults_tb_top import pad_reset_pkg::*;;
	logic       clk_sys = 1'b0;
	logic       rst_n   = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, port_e_buf_en_ff;
	logic       reg_wr, reg_rd, reset_pin_in, reset_pin_out_ff, reset_pin_oe_ff;
	logic       clock_monitor_fail, watchdog_timer_fail, button;
	logic       debug_line_pullup_ff, device_reset_n_ff, clk_from_osc_ff, osc_div_clk_ff;
	logic [2:0] mode_pins;
	logic [5:0] rise_cycles;
	logic [7:0] drv [9];
	pull_t      pl [9];
	int         miscompares, check_count;

	always #2.5 clk_sys = ~clk_sys;

	pad_reset_defaults #(.DRIVE_CYCLES(4), .RELEASE_CYCLES(4)) DUT (.clk_sys, .rst_n,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .reset_pin_in,
		.reset_pin_out_ff, .reset_pin_oe_ff, .clock_monitor_fail, .watchdog_timer_fail,
		.mode_pins, .drive_en_a(drv[0]), .drive_en_b(drv[1]), .drive_en_e(drv[2]),
		.drive_en_ad(drv[3]), .drive_en_p(drv[4]), .drive_en_j(drv[5]), .drive_en_t(drv[6]),
		.drive_en_m(drv[7]), .drive_en_s(drv[8]), .debug_line_pullup_ff, .pull_a_ff(pl[0]),
		.pull_b_ff(pl[1]), .pull_e_ff(pl[2]), .pull_ad_ff(pl[3]), .pull_p_ff(pl[4]),
		.pull_j_ff(pl[5]), .pull_t_ff(pl[6]), .pull_m_ff(pl[7]), .pull_s_ff(pl[8]),
		.port_e_buf_en_ff, .device_reset_n_ff, .clk_from_osc_ff, .osc_div_clk_ff);

	board_reset_model board (.clk_sys, .pin_out(reset_pin_out_ff), .pin_oe(reset_pin_oe_ff),
		.button, .rise_cycles, .pin_level(reset_pin_in));

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_ff}, {8'h00, e});
	endtask
	// Bounded wait for normal processing
	task automatic wait_run();
		for (int i = 0; i < 300 && device_reset_n_ff !== 1'b1; i++) tick(1);
		if (device_reset_n_ff !== 1'b1) begin
			miscompares++;
			close_out();
		end
		tick(3);
	endtask
	task automatic t_defaults();
		logic half;
		// Bus clock tick is the oscillator halved, so it flips every cycle
		half = osc_div_clk_ff;
		tick(1);
		chk({15'h0000, osc_div_clk_ff}, {15'h0000, ~half});
		chk(pl[0], 16'h0000);
		chk(pl[1], 16'h0000);
		chk(pl[2], 16'h9F00);
		for (int i = 3; i < 7; i++) chk(pl[i], 16'h0000);
		chk(pl[7], 16'hFF00);
		chk(pl[8], 16'hFF00);
		chk({14'h0000, debug_line_pullup_ff, clk_from_osc_ff}, 16'h0003);
		rdchk(OFS_PULLUP_CTRL, RST_PULLUP_CTRL);
		rdchk(OFS_S_PE, RST_PE_ONES);
		rdchk(OFS_RST_STATUS, 8'h08);
		rdchk(8'h0F, 8'h00);
	endtask
	task automatic t_pullup();
		wr(OFS_PULLUP_CTRL, 8'h03);
		tick(2);
		chk(pl[0], 16'hFF00);
		chk(pl[1], 16'hFF00);
		chk(pl[2], 16'h0000);
	endtask
	// Bits 7:6 only, so the narrow wake port gives the same answer
	task automatic t_ports();
		for (int k = 0; k < 6; k++) begin
			wr(OFS_AD_PE + 8'(2 * k), 8'hC0);
			wr(OFS_AD_PS + 8'(2 * k), 8'h40);
			tick(2);
			chk(pl[3 + k], 16'h8040);
			drv[3 + k] <= 8'h40;
			tick(2);
			chk(pl[3 + k], 16'h8000);
			drv[3 + k] <= 8'h00;
		end
	endtask
	task automatic t_pin();
		rise_cycles <= 6'd12;
		button <= 1'b1;
		tick(3);
		button <= 1'b0;
		tick(40);
		chk({15'h0000, device_reset_n_ff}, 16'h0000);
		chk(pl[2].down, 16'h0060);
		rise_cycles <= 6'd1;
		wait_run();
		rdchk(OFS_PULLUP_CTRL, RST_PULLUP_CTRL);
		rdchk(OFS_M_PS, RST_PS_ZERO);
	endtask
	task automatic t_fail(input int src);
		if (src == 0) clock_monitor_fail <= 1'b1;
		else watchdog_timer_fail <= 1'b1;
		for (int i = 0; i < 10 && reset_pin_oe_ff !== 1'b1; i++) tick(1);
		chk({reset_pin_oe_ff, reset_pin_out_ff}, 16'h0002);
		clock_monitor_fail <= 1'b0;
		watchdog_timer_fail <= 1'b0;
		wait_run();
	endtask
	task automatic t_mode(input logic [2:0] m, input logic [7:0] pea);
		mode_pins <= m;
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		wait_run();
		rdchk(OFS_PORT_E_ASSGN, pea);
		chk({8'h00, port_e_buf_en_ff & 8'h1C}, {8'h00, pea & 8'h1C});
		chk({8'h00, pl[2].up & pea}, 16'h0000);
	endtask

	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{clock_monitor_fail, watchdog_timer_fail, button} = '0;
		mode_pins = 3'h0;
		rise_cycles = 6'd1;
		foreach (drv[i]) drv[i] = 8'h00;
		miscompares = 0;
		check_count = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_run();
		t_defaults();
		t_pullup();
		t_ports();
		t_pin();
		t_fail(0);
		t_fail(1);
		t_mode(MODE_SPECIAL_TEST, PEA_SPECIAL_TEST);
		t_mode(3'h1, PEA_EXPANDED);
		t_mode(3'h0, PEA_SINGLE_CHIP);
		close_out();
	end
endmodule // pad_reset_defaults_tb_top

// >>> verilog/pad_reset_defaults.sv
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - Ports A,B reset with pulls off
// RULE_02 - Debug line pull-up always on
// RULE_03 - PE7 resets pulled up, software controlled
// RULE_04 - PE6,PE5 pull down only during reset
// RULE_05 - PE4..2 buffers, pulls follow mode assignment
// RULE_06 - PE1,PE0 reset with pull-ups on
// RULE_07 - Port AD pulls off, enable/polarity registers
// RULE_08 - Ports P,J,T pulls off at reset
// RULE_09 - Port M pulls up at reset
// RULE_10 - Port S pulls up at reset
// RULE_11 - Software pulls up unbonded input pins
// RULE_12 - Clocks derive from oscillator after reset
// RULE_13 - Low reset pin initialises whole device
// RULE_14 - Failures pull reset low, open drain
// RULE_15 - Any reset drives pin, runs sequence
// RULE_16 - Board lets pin rise within 32 cycles
// RULE_17 - Clearing port E enable drops interrupt pulls
// RULE_18 - Pulls only act on input pins
module pad_reset_defaults
	import pad_reset_pkg::*;
#(
	parameter int DRIVE_CYCLES   = RST_DRIVE_CYCLES,
	parameter int RELEASE_CYCLES = RST_RELEASE_CYCLES
)(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata_ff,
	// Reset pin, open drain
	input  wire logic       reset_pin_in,
	output logic            reset_pin_out_ff,
	output logic            reset_pin_oe_ff,
	// Internal failure, mode and pin drive-enable inputs
	input  wire logic       clock_monitor_fail,
	input  wire logic       watchdog_timer_fail,
	input  wire logic [2:0] mode_pins,
	input  wire logic [7:0] drive_en_a,
	input  wire logic [7:0] drive_en_b,
	input  wire logic [7:0] drive_en_e,
	input  wire logic [7:0] drive_en_ad,
	input  wire logic [7:0] drive_en_p,
	input  wire logic [7:0] drive_en_j,
	input  wire logic [7:0] drive_en_t,
	input  wire logic [7:0] drive_en_m,
	input  wire logic [7:0] drive_en_s,
	// Pull outputs
	output logic            debug_line_pullup_ff,
	output pull_t           pull_a_ff,
	output pull_t           pull_b_ff,
	output pull_t           pull_e_ff,
	output pull_t           pull_ad_ff,
	output pull_t           pull_p_ff,
	output pull_t           pull_j_ff,
	output pull_t           pull_t_ff,
	output pull_t           pull_m_ff,
	output pull_t           pull_s_ff,
	output logic      [7:0] port_e_buf_en_ff,
	// Sequencer outputs
	output logic            device_reset_n_ff,
	output logic            clk_from_osc_ff,
	output logic            osc_div_clk_ff
);

	initial begin
		if (DRIVE_CYCLES < 1 || DRIVE_CYCLES > 65535)
			$error("DRIVE_CYCLES out of range");
		if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > 65535)
			$error("RELEASE_CYCLES out of range");
	end

	// Synchronisers for the pin, mode strap and asynchronous failure inputs
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end else begin
			sync1_ff <= {~reset_pin_in, clock_monitor_fail, watchdog_timer_fail, mode_pins};
			sync2_ff <= sync1_ff;
		end
	end
	logic       pin_low;
	logic       fail_any;
	logic [2:0] mode_sync;
	assign pin_low   = sync2_ff[5];
	assign fail_any  = sync2_ff[4] | sync2_ff[3];
	assign mode_sync = sync2_ff[2:0];

	// Reset sequencer
	seq_state_t  state_ff;
	seq_state_t  nxt_state;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        mode_load_ff;
	logic        nxt_mode_load;
	localparam logic [15:0] DRIVE_LAST   = 16'(DRIVE_CYCLES - 1);
	localparam logic [15:0] RELEASE_LAST = 16'(RELEASE_CYCLES - 1);

	always_comb begin
		nxt_state     = state_ff;
		nxt_cnt       = cnt_ff;
		nxt_mode_load = 1'b0;
		case (state_ff)
			SEQ_IDLE: begin
				nxt_state = SEQ_DRIVE;
				nxt_cnt   = 16'h0000;
			end
			SEQ_DRIVE: begin
				// Pin held low for DRIVE_CYCLES; the mode latches at the end of the release phase
				if (cnt_ff == DRIVE_LAST) begin
					nxt_state = SEQ_RELEASE;
					nxt_cnt   = 16'h0000;
				end else begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
			end
			SEQ_RELEASE: begin
				// Board has this long to let the pin rise
				if (cnt_ff == RELEASE_LAST) begin // see RULE_16
					nxt_cnt = 16'h0000;
					if (!pin_low) begin
						nxt_state     = SEQ_RUN;
						nxt_mode_load = 1'b1;
					end else begin
						nxt_state = SEQ_DRIVE;
					end
				end else begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
			end
			SEQ_RUN: begin
				if (pin_low || fail_any) begin // see RULE_13
					nxt_state = SEQ_DRIVE; // see RULE_14
					nxt_cnt   = 16'h0000;
				end
			end
			default: begin
				nxt_state = SEQ_IDLE;
				nxt_cnt   = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= SEQ_IDLE;
			cnt_ff       <= 16'h0000;
			mode_load_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			mode_load_ff <= nxt_mode_load;
		end
	end

	logic in_reset;
	assign in_reset = (state_ff != SEQ_RUN);

	// Pin outputs: open drain, only ever low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reset_pin_out_ff  <= 1'b0;
			reset_pin_oe_ff   <= 1'b1;
			device_reset_n_ff <= 1'b0;
		end else begin
			reset_pin_out_ff  <= 1'b0; // see RULE_14
			reset_pin_oe_ff   <= (nxt_state == SEQ_DRIVE) || (nxt_state == SEQ_IDLE); // see RULE_15
			device_reset_n_ff <= (nxt_state == SEQ_RUN); // see RULE_13
		end
	end

	// Clock source is always the oscillator; no register selects another
	logic [1:0] div_ff;
	logic [1:0] nxt_div;
	always_comb begin
		nxt_div = (div_ff == 2'(OSC_DIV - 1)) ? 2'h0 : div_ff + 2'h1;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_ff          <= 2'h0;
			osc_div_clk_ff  <= 1'b0;
			clk_from_osc_ff <= 1'b1;
		end else begin
			div_ff          <= nxt_div;
			osc_div_clk_ff  <= (div_ff == 2'h0); // see RULE_12
			clk_from_osc_ff <= 1'b1; // see RULE_12
		end
	end

	// Registers
	logic [7:0] puc_ff, pea_ff;
	logic [7:0] pe_ff [6];
	logic [7:0] ps_ff [6];
	logic [7:0] nxt_puc, nxt_pea;
	logic [7:0] nxt_pe [6];
	logic [7:0] nxt_ps [6];
	logic [7:0] mode_pea;

	// Mode decides port E assignment at reset
	always_comb begin
		if (mode_sync == MODE_SPECIAL_TEST)
			mode_pea = PEA_SPECIAL_TEST; // see RULE_05
		else if (mode_sync[0])
			mode_pea = PEA_EXPANDED;
		else
			mode_pea = PEA_SINGLE_CHIP;
	end

	always_comb begin
		nxt_puc = puc_ff;
		nxt_pea = pea_ff;
		for (int i = 0; i < 6; i++) begin
			nxt_pe[i] = pe_ff[i];
			nxt_ps[i] = ps_ff[i];
		end
		if (mode_load_ff)
			nxt_pea = mode_pea; // see RULE_05
		if (reg_wr) begin
			if (reg_addr == OFS_PULLUP_CTRL)
				nxt_puc = reg_wdata; // see RULE_17
			if (reg_addr == OFS_PORT_E_ASSGN)
				nxt_pea = reg_wdata;
			for (int i = 0; i < 6; i++) begin
				if (reg_addr == OFS_AD_PE + 8'(2 * i))
					nxt_pe[i] = reg_wdata; // see RULE_07
				if (reg_addr == OFS_AD_PS + 8'(2 * i))
					nxt_ps[i] = reg_wdata; // see RULE_08
			end
		end
		// Ports M and S (indices 4,5) pull up; others off
		if (in_reset) begin
			nxt_puc = RST_PULLUP_CTRL; // see RULE_01
			for (int i = 0; i < 6; i++) begin
				nxt_pe[i] = (i >= 4) ? RST_PE_ONES : RST_PE_ZERO; // see RULE_09
				nxt_ps[i] = RST_PS_ZERO; // see RULE_10
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			puc_ff <= RST_PULLUP_CTRL;
			pea_ff <= PEA_SINGLE_CHIP;
			for (int i = 0; i < 6; i++) begin
				pe_ff[i] <= (i >= 4) ? RST_PE_ONES : RST_PE_ZERO;
				ps_ff[i] <= RST_PS_ZERO;
			end
		end else begin
			puc_ff <= nxt_puc;
			pea_ff <= nxt_pea;
			for (int i = 0; i < 6; i++) begin
				pe_ff[i] <= nxt_pe[i];
				ps_ff[i] <= nxt_ps[i];
			end
		end
	end

	// Port E buffers and pulls
	logic [7:0] e_buf;
	logic [7:0] e_pe;
	logic [7:0] e_ps;
	always_comb begin
		e_buf                 = drive_en_e;
		e_buf[1:0]            = 2'b00; // Interrupt pins are input only
		e_buf[PEA_RW_EN]      = drive_en_e[PEA_RW_EN] | pea_ff[PEA_RW_EN]; // see RULE_05
		e_buf[PEA_LSTR_EN]    = drive_en_e[PEA_LSTR_EN] | pea_ff[PEA_LSTR_EN]; // see RULE_05
		e_buf[PEA_BUS_CLOCK_OUTPUT_EN]    = drive_en_e[PEA_BUS_CLOCK_OUTPUT_EN] | pea_ff[PEA_BUS_CLOCK_OUTPUT_EN]; // see RULE_05
		e_pe                  = {8{puc_ff[PUC_PORT_E]}}; // see RULE_03
		e_pe[1:0]             = {2{puc_ff[PUC_PORT_E]}}; // see RULE_06
		e_pe[6:5]             = {2{in_reset}}; // see RULE_04
		e_ps                  = 8'h00;
		e_ps[6:5]             = 2'b11; // see RULE_04
	end

	pull_t pa, pb, pe, pad, pp, pj, pt, pm, ps;
	port_pull_cell u_a (.enable({8{puc_ff[PUC_PORT_A]}}), .polarity(8'h00),
		.drive_en(drive_en_a), .pull(pa)); // see RULE_01
	port_pull_cell u_b (.enable({8{puc_ff[PUC_PORT_B]}}), .polarity(8'h00),
		.drive_en(drive_en_b), .pull(pb)); // see RULE_01
	port_pull_cell u_e (.enable(e_pe), .polarity(e_ps), .drive_en(e_buf), .pull(pe));
	port_pull_cell u_ad (.enable(pe_ff[0]), .polarity(ps_ff[0]),
		.drive_en(drive_en_ad), .pull(pad)); // see RULE_07
	port_pull_cell u_p (.enable(pe_ff[1]), .polarity(ps_ff[1]),
		.drive_en(drive_en_p), .pull(pp)); // see RULE_08
	port_pull_cell u_j (.enable(pe_ff[2]), .polarity(ps_ff[2]),
		.drive_en(drive_en_j), .pull(pj)); // see RULE_08
	port_pull_cell u_t (.enable(pe_ff[3]), .polarity(ps_ff[3]),
		.drive_en(drive_en_t), .pull(pt)); // see RULE_08
	port_pull_cell u_m (.enable(pe_ff[4]), .polarity(ps_ff[4]),
		.drive_en(drive_en_m), .pull(pm)); // see RULE_09
	port_pull_cell u_s (.enable(pe_ff[5]), .polarity(ps_ff[5]),
		.drive_en(drive_en_s), .pull(ps)); // see RULE_10

	// Registered outputs and read port
	logic [7:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == OFS_PULLUP_CTRL)
				nxt_rdata = puc_ff;
			if (reg_addr == OFS_PORT_E_ASSGN)
				nxt_rdata = pea_ff;
			for (int i = 0; i < 6; i++) begin
				if (reg_addr == OFS_AD_PE + 8'(2 * i))
					nxt_rdata = pe_ff[i];
				if (reg_addr == OFS_AD_PS + 8'(2 * i))
					nxt_rdata = ps_ff[i];
			end
			if (reg_addr == OFS_RST_STATUS)
				nxt_rdata = {4'h0, state_ff};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff         <= 8'h00;
			debug_line_pullup_ff <= 1'b1;
			pull_a_ff            <= '0;
			pull_b_ff            <= '0;
			pull_e_ff            <= RST_PULL_E; // see RULE_03 RULE_04 RULE_06
			pull_ad_ff           <= '0;
			pull_p_ff            <= '0;
			pull_j_ff            <= '0;
			pull_t_ff            <= '0;
			pull_m_ff            <= RST_PULL_SER; // see RULE_09
			pull_s_ff            <= RST_PULL_SER; // see RULE_10
			port_e_buf_en_ff     <= 8'h00;
		end else begin
			reg_rdata_ff         <= nxt_rdata;
			debug_line_pullup_ff <= 1'b1; // see RULE_02
			pull_a_ff            <= pa;
			pull_b_ff            <= pb;
			pull_e_ff            <= pe;
			pull_ad_ff           <= pad;
			pull_p_ff            <= pp;
			pull_j_ff            <= pj;
			pull_t_ff            <= pt;
			pull_m_ff            <= pm;
			pull_s_ff            <= ps;
			port_e_buf_en_ff     <= e_buf;
		end
	end

endmodule // pad_reset_defaults

// >>> verilog/pad_reset_pkg.sv
package pad_reset_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] OFS_PULLUP_CTRL  = 8'h00;
	localparam logic [7:0] OFS_PORT_E_ASSGN = 8'h01;
	localparam logic [7:0] OFS_AD_PE        = 8'h02;
	localparam logic [7:0] OFS_AD_PS        = 8'h03;
	localparam logic [7:0] OFS_P_PE         = 8'h04;
	localparam logic [7:0] OFS_P_PS         = 8'h05;
	localparam logic [7:0] OFS_J_PE         = 8'h06;
	localparam logic [7:0] OFS_J_PS         = 8'h07;
	localparam logic [7:0] OFS_T_PE         = 8'h08;
	localparam logic [7:0] OFS_T_PS         = 8'h09;
	localparam logic [7:0] OFS_M_PE         = 8'h0A;
	localparam logic [7:0] OFS_M_PS         = 8'h0B;
	localparam logic [7:0] OFS_S_PE         = 8'h0C;
	localparam logic [7:0] OFS_S_PS         = 8'h0D;
	localparam logic [7:0] OFS_RST_STATUS   = 8'h0E;

	// Pull-up control register fields
	localparam int PUC_PORT_A = 0;
	localparam int PUC_PORT_B = 1;
	localparam int PUC_PORT_E = 4;

	// Port E assignment register fields
	localparam int PEA_RW_EN   = 2;
	localparam int PEA_LSTR_EN = 3;
	localparam int PEA_BUS_CLOCK_OUTPUT_EN = 4;

	// Reset values
	localparam logic [7:0] RST_PULLUP_CTRL = 8'h10;
	localparam logic [7:0] RST_PE_ZERO     = 8'h00;
	localparam logic [7:0] RST_PE_ONES     = 8'hFF;
	localparam logic [7:0] RST_PS_ZERO     = 8'h00;
	localparam logic [7:0] PEA_SPECIAL_TEST = 8'h0C;
	localparam logic [7:0] PEA_EXPANDED     = 8'h10;
	localparam logic [7:0] PEA_SINGLE_CHIP  = 8'h00;

	// Mode codes {c,b,a}
	localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;

	// Reset sequence timing
	localparam int RST_DRIVE_CYCLES   = 128;
	localparam int RST_RELEASE_CYCLES = 32;
	localparam int OSC_DIV            = 2;

	typedef enum logic [3:0] {
		SEQ_IDLE    = 4'b0001,
		SEQ_DRIVE   = 4'b0010,
		SEQ_RELEASE = 4'b0100,
		SEQ_RUN     = 4'b1000
	} seq_state_t;

	// Pull configuration for an eight-bit port
	typedef struct packed {
		logic [7:0] up;
		logic [7:0] down;
	} pull_t;

	// Pull state while reset is held: port E bits 7 and 4..0 up, 6..5 down
	localparam pull_t RST_PULL_E   = '{up: 8'h9F, down: 8'h60};
	// Serial ports M and S come out of reset pulled up
	localparam pull_t RST_PULL_SER = '{up: 8'hFF, down: 8'h00};

endpackage

// >>> verilog/port_pull_cell.sv
`timescale 1ns/1ps
module port_pull_cell
	import pad_reset_pkg::*;
(
	// Configuration
	input  wire logic [7:0] enable,
	input  wire logic [7:0] polarity,
	input  wire logic [7:0] drive_en,
	// Result
	output pull_t           pull
);

	// Pull removed while the output driver is on
	always_comb begin
		pull.up   = enable & ~polarity & ~drive_en; // see RULE_18
		pull.down = enable &  polarity & ~drive_en; // see RULE_18
	end

endmodule // port_pull_cell
